// ===== gpc_pkg.sv
// constants for the single-pin control block and its register map
package gpc_pkg;

  // register indexes; byte address is four times the index
  localparam logic [15:0] GPC_IDX_CTRL = 16'h403d;
  localparam logic [15:0] GPC_IDX_STAT = 16'h4040;
  localparam logic [15:0] GPC_IDX_MASK = 16'h4041;
  localparam logic [15:0] GPC_IDX_DATA = 16'h4042;

  // control field positions
  localparam int GPC_B_DIR   = 15;
  localparam int GPC_B_PULLH = 14;
  localparam int GPC_B_PULLL = 13;
  localparam int GPC_B_MODE  = 12;
  localparam int GPC_B_DOM   = 11;
  localparam int GPC_B_POL   = 10;
  localparam int GPC_B_OD    = 9;
  localparam int GPC_B_ENA   = 7;
  localparam int GPC_B_FNH   = 3;

  // writable bits of the control word and its reset value
  localparam logic [15:0] GPC_CTRL_WMASK = 16'hfe8f;
  localparam logic [15:0] GPC_CTRL_RST   = 16'ha400;

  // pull codes
  localparam logic [1:0] GPC_PULL_NONE = 2'h0;
  localparam logic [1:0] GPC_PULL_DOWN = 2'h1;
  localparam logic [1:0] GPC_PULL_UP   = 2'h2;

  // data register fields
  localparam int GPC_D_OUT = 0;
  localparam int GPC_D_IN  = 1;

  // input function codes with long debounce
  localparam logic [3:0] GPC_FN_GPIN_LONG = 4'h0;
  localparam logic [3:0] GPC_FN_SLWK_LONG = 4'h4;
  localparam logic [3:0] GPC_FN_CTL1_LONG = 4'he;
  localparam logic [3:0] GPC_FN_CTL2_LONG = 4'hf;

endpackage : gpc_pkg

// ===== gpc_pin_control.sv
// one general-purpose pin: control register, function routing, edge interrupt
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module gpc_pin_control #(
  parameter int ADDR_W = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pull_up_en,
  output logic                   pull_down_en,
  output logic                   supply_sel_system,
  output logic                   long_debounce,
  output logic      [15:0]       input_function_level,
  input  wire logic              osc_32k,
  input  wire logic              on_state,
  input  wire logic              sleep_state,
  input  wire logic              power_state_change,
  input  wire logic              pen_down,
  input  wire logic              conversion_done,
  input  wire logic              scaling_done_one,
  input  wire logic              scaling_done_two,
  input  wire logic              ext_power_enable_one,
  input  wire logic              ext_power_enable_two,
  input  wire logic              system_supply_good,
  input  wire logic              converter_power_good,
  input  wire logic              ext_power_clock,
  input  wire logic              aux_reset
);
  import gpc_pkg::*;

  logic [15:0] ctrl_q;
  logic        stat_q;
  logic        mask_q;
  logic        out_val_q;
  logic        pin_prev_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        pin_out_q;
  logic        pin_oe_q;
  logic        pull_up_q;
  logic        pull_dn_q;
  logic        dom_q;
  logic        long_db_q;
  logic [15:0] in_fn_q;

  // register index of a byte address; low two bits ignored
  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = 16'(a >> 2);
  endfunction

  // input codes whose debounce is the long one
  function automatic logic is_long(input logic [3:0] fn);
    case (fn)
      GPC_FN_GPIN_LONG: is_long = 1'b1;
      GPC_FN_SLWK_LONG: is_long = 1'b1;
      GPC_FN_CTL1_LONG: is_long = 1'b1;
      GPC_FN_CTL2_LONG: is_long = 1'b1;
      default:          is_long = 1'b0;
    endcase
  endfunction

  // pull code to {up, down}; the reserved code applies neither
  function automatic logic [1:0] pull_decode(input logic [1:0] code);
    case (code)
      GPC_PULL_UP:   pull_decode = 2'b10;
      GPC_PULL_DOWN: pull_decode = 2'b01;
      GPC_PULL_NONE: pull_decode = 2'b00;
      default:       pull_decode = 2'b00;
    endcase
  endfunction

  // register index that the block answers to
  function automatic logic is_mapped(input logic [15:0] i);
    case (i)
      GPC_IDX_CTRL: is_mapped = 1'b1;
      GPC_IDX_STAT: is_mapped = 1'b1;
      GPC_IDX_MASK: is_mapped = 1'b1;
      GPC_IDX_DATA: is_mapped = 1'b1;
      default:      is_mapped = 1'b0;
    endcase
  endfunction

  // control fields
  logic       dir_in;
  logic [1:0] pull;
  logic       both_edges;
  logic       pol_high;
  logic       open_drain;
  logic       enabled;
  logic [3:0] fn;
  assign dir_in     = ctrl_q[GPC_B_DIR];
  assign pull       = ctrl_q[GPC_B_PULLH:GPC_B_PULLL];
  assign both_edges = ctrl_q[GPC_B_MODE];
  assign pol_high   = ctrl_q[GPC_B_POL];
  assign open_drain = ctrl_q[GPC_B_OD];
  assign enabled    = ctrl_q[GPC_B_ENA];
  assign fn         = ctrl_q[GPC_B_FNH:0];

  // bus decode; first access cycle answers next cycle, one wait state always
  logic        acc;
  logic        wr_ok;
  logic [15:0] idx;
  logic        mapped;
  assign acc    = psel && penable && !pready_q;
  assign wr_ok  = psel && penable && pready_q && pwrite && !pslverr_q;
  assign idx    = reg_index(paddr);
  assign mapped = is_mapped(idx);

  // one strobe per register, shared by every write path below
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_data;
  assign wr_ctrl = wr_ok && (idx == GPC_IDX_CTRL);
  assign wr_stat = wr_ok && (idx == GPC_IDX_STAT);
  assign wr_mask = wr_ok && (idx == GPC_IDX_MASK);
  assign wr_data = wr_ok && (idx == GPC_IDX_DATA);

  // read word of the addressed register; unmapped reads zero
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      GPC_IDX_CTRL: rd_word = {16'h0000, ctrl_q};
      GPC_IDX_STAT: rd_word = {31'h0000_0000, stat_q};
      GPC_IDX_MASK: rd_word = {31'h0000_0000, mask_q};
      GPC_IDX_DATA: rd_word = {30'h0000_0000, pin_in, out_val_q};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // ready pulses once, in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc;
    end
  end

  // error travels with ready so the master sees both at one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= acc && !mapped;
    end
  end

  // read data captured with ready, held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (acc && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  // control register; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= GPC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[15:0] & GPC_CTRL_WMASK;
    end
  end

  // interrupt mask, one bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 1'b0;
    end else if (wr_mask) begin
      mask_q <= pwdata[0];
    end
  end

  // value driven for the plain output function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_val_q <= 1'b0;
    end else if (wr_data) begin
      out_val_q <= pwdata[GPC_D_OUT];
    end
  end

  // edge detect on the raw pin; inputs are already synchronous
  logic rise;
  logic fall;
  logic edge_evt;
  assign rise = pin_in && !pin_prev_q;
  assign fall = !pin_in && pin_prev_q;

  // edge qualifier per interrupt mode; output pins never raise events
  always_comb begin
    edge_evt = 1'b0;
    if (dir_in && enabled) begin
      case (both_edges)
        1'b1:    edge_evt = rise || fall;
        1'b0:    edge_evt = pol_high ? rise : fall;
        default: edge_evt = 1'b0;
      endcase
    end
  end

  // previous pin sample; resets to the pulled-down idle level

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_prev_q <= 1'b0;
    else          pin_prev_q <= pin_in;
  end

  // sticky status, write one to clear; a new edge wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 1'b0;
    end else if (edge_evt) begin
      stat_q <= 1'b1;
    end else if (wr_stat && pwdata[0]) begin
      stat_q <= 1'b0;
    end
  end

  // level interrupt; one cycle behind the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else          irq_q <= stat_q && mask_q;
  end

  // output source chosen by function code; reserved code selects low, before polarity
  logic lvl;
  logic phys;
  always_comb begin
    lvl = 1'b0;
    case (fn)
      4'h0:    lvl = out_val_q;
      4'h1:    lvl = osc_32k;
      4'h2:    lvl = on_state;
      4'h3:    lvl = sleep_state;
      4'h4:    lvl = power_state_change;
      4'h5:    lvl = 1'b0;
      4'h6:    lvl = pen_down;
      4'h7:    lvl = conversion_done;
      4'h8:    lvl = scaling_done_one;
      4'h9:    lvl = scaling_done_two;
      4'ha:    lvl = ext_power_enable_one;
      4'hb:    lvl = ext_power_enable_two;
      4'hc:    lvl = system_supply_good;
      4'hd:    lvl = converter_power_good;
      4'he:    lvl = ext_power_clock;
      4'hf:    lvl = aux_reset;
      default: lvl = 1'b0;
    endcase
  end

  // pin drive: polarity, then push-pull or open drain, then enable
  assign phys = pol_high ? lvl : !lvl;

  // driven level; open drain only ever pulls low, so it is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
    end else begin
      pin_out_q <= open_drain ? 1'b0 : phys;
    end
  end

  // output enable; open drain releases the pin for a high level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= enabled && !dir_in &&
                  (open_drain ? !phys : 1'b1);
    end
  end

  // pull-up control; reserved pull code applies none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_q <= 1'b0;
    end else begin
      pull_up_q <= pull_decode(pull)[1];
    end
  end

  // pull-down control, on from reset so the pad does not float out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_dn_q <= 1'b1;
    end else begin
      pull_dn_q <= pull_decode(pull)[0];
    end
  end

  // supply-domain select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_q <= 1'b0;
    end else begin
      dom_q <= ctrl_q[GPC_B_DOM];
    end
  end

  // input function routing: logical level lands on the selected code
  logic        in_lvl;
  logic [15:0] route;
  assign in_lvl = pol_high ? pin_in : !pin_in;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_route
      assign route[g] = dir_in && enabled && (fn == 4'(g)) && in_lvl;
    end
  endgenerate

  // routed input levels, one flop per function code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_fn_q <= 16'h0000;
    end else begin
      in_fn_q <= route;
    end
  end

  // debounce length request; code 0 after reset wants the long one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_db_q <= 1'b1;
    end else begin
      long_db_q <= is_long(fn);
    end
  end

  // outputs straight from their flops

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign irq                  = irq_q;
  assign pin_out              = pin_out_q;
  assign pin_oe               = pin_oe_q;
  assign pull_up_en           = pull_up_q;
  assign pull_down_en         = pull_dn_q;
  assign supply_sel_system    = dom_q;
  assign long_debounce        = long_db_q;
  assign input_function_level = in_fn_q;

endmodule // gpc_pin_control

// ===== gpc_pin_control_props.sv
// assertion checker for the single-pin control block
`timescale 1ns/10ps
module gpc_pin_control_props
  import gpc_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pin_out,
  input wire logic              pin_oe,
  input wire logic              pull_up_en,
  input wire logic              pull_down_en,
  input wire logic              supply_sel_system,
  input wire logic              long_debounce,
  input wire logic [15:0]       input_function_level,
  input wire logic              osc_32k
);
  logic [15:0] ctrl_q;
  // shadow of the control word, committed on the same edge as the slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= GPC_CTRL_RST;
    else if (psel && penable && pready && pwrite && paddr == {GPC_IDX_CTRL, 2'b00})
      ctrl_q <= pwdata[15:0] & GPC_CTRL_WMASK;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outputs lag the control word by one edge, hence the $past on it
  property p_oe; pin_oe |-> $past(ctrl_q[GPC_B_ENA]) && !$past(ctrl_q[GPC_B_DIR]); endproperty
  a_oe: assert property (p_oe) else $error("pin driven while input or disabled");
  property p_pp; $past(!ctrl_q[GPC_B_DIR] && ctrl_q[GPC_B_ENA] && !ctrl_q[GPC_B_OD]) |-> pin_oe; endproperty
  a_pp: assert property (p_pp) else $error("push-pull output not driven");
  property p_od; pin_oe && $past(ctrl_q[GPC_B_OD]) |-> !pin_out; endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_pull; {pull_up_en, pull_down_en} == {$past(ctrl_q[14:13]) == GPC_PULL_UP,
    $past(ctrl_q[14:13]) == GPC_PULL_DOWN}; endproperty
  a_pull: assert property (p_pull) else $error("pull enables wrong");
  property p_dom; supply_sel_system == $past(ctrl_q[GPC_B_DOM]); endproperty
  a_dom: assert property (p_dom) else $error("supply select wrong");
  property p_long; long_debounce == ($past(ctrl_q[3:0]) inside {4'h0, 4'h4, 4'he, 4'hf}); endproperty
  a_long: assert property (p_long) else $error("long debounce wrong");
  property p_fn; (input_function_level & ~(16'h0001 << $past(ctrl_q[3:0]))) == 16'h0000; endproperty
  a_fn: assert property (p_fn) else $error("input function misrouted");
  property p_osc; $past(ctrl_q & 16'h868f) == 16'h0481 |-> pin_out == $past(osc_32k); endproperty
  a_osc: assert property (p_osc) else $error("oscillator not routed");
endmodule // gpc_pin_control_props

bind gpc_pin_control gpc_pin_control_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ===== gpc_pin_model.sv
// external circuitry on the pad: resolves the wire level seen by the pin
`timescale 1ns/10ps
module gpc_pin_model (
  input  wire logic pclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  input  wire logic ext_en,
  input  wire logic ext_lvl,
  output logic      pin_in
);
  logic flt_q = 1'b0;
  // a floating pad wanders, so a stale level never reads back as valid
  always_ff @(posedge pclk) flt_q <= !flt_q;
  // device drive wins, then far-side driver, then the pulls
  assign pin_in = pin_oe ? pin_out : ext_en ? ext_lvl :
                  pull_up_en ? 1'b1 : pull_down_en ? 1'b0 : flt_q;
endmodule // gpc_pin_model

// ===== gpio6_pin_control_tb.sv
// self-checking testbench for the single-pin control block
`timescale 1ns/10ps
module gpio6_pin_control_tb;
  import gpc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        ext_en = 0, ext_lvl = 0, rerr;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [15:0] src = '0, input_function_level;
  logic        pready, pslverr, irq, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic        supply_sel_system, long_debounce, osc_32k, on_state, sleep_state;
  logic        power_state_change, pen_down, conversion_done, scaling_done_one;
  logic        scaling_done_two, ext_power_enable_one, ext_power_enable_two;
  logic        system_supply_good, converter_power_good, ext_power_clock, aux_reset;
  int          error_cnt = 0, n_tests = 0;
  // source bit n feeds output function code n
  assign {aux_reset, ext_power_clock, converter_power_good, system_supply_good,
          ext_power_enable_two, ext_power_enable_one, scaling_done_two, scaling_done_one,
          conversion_done, pen_down, power_state_change, sleep_state, on_state,
          osc_32k} = {src[15:6], src[4:1]};
  gpc_pin_control u_dut (.*);
  gpc_pin_model u_pad (.*);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; an idle edge first keeps transfers from colliding
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task automatic t_reset();
    chk("pull down", 32'(pull_down_en), 32'h0000_0001);
    apb(1'b0, GPC_IDX_CTRL, '0);
    chk("ctrl reset", rdat, 32'h0000_a400);
    apb(1'b0, 16'h0001, '0);
    chk("unmapped", rdat, 32'h0000_0000);
    chk("slverr", 32'(rerr), 32'h0000_0001);
    apb(1'b1, GPC_IDX_CTRL, 32'hffff_ffff);
    apb(1'b0, GPC_IDX_CTRL, '0);
    chk("ctrl mask", rdat, 32'h0000_fe8f);
    $display("done reset");
  endtask
  task automatic t_out();
    apb(1'b1, GPC_IDX_DATA, 32'h0000_0001);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, GPC_IDX_CTRL, 32'h0000_0480 | c);
      src <= 16'h0001 << c;
      repeat (2) @(posedge pclk);
      chk("routed out", 32'({pin_oe, pin_out}), (c == 5) ? 32'h2 : 32'h3);
    end
    apb(1'b1, GPC_IDX_CTRL, 32'h0000_4680);
    apb(1'b1, GPC_IDX_DATA, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("od low", 32'({pin_oe, pin_out}), 32'h0000_0002);
    apb(1'b1, GPC_IDX_DATA, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("od release", 32'({pin_oe, pin_in}), 32'h0000_0001);
    apb(1'b1, GPC_IDX_CTRL, 32'h0000_0400);
    repeat (2) @(posedge pclk);
    chk("tristate", 32'(pin_oe), 32'h0000_0000);
    apb(1'b1, GPC_IDX_CTRL, 32'h0000_0c00);
    repeat (2) @(posedge pclk);
    chk("supply select", 32'(supply_sel_system), 32'h0000_0001);
    $display("done output");
  endtask
  task automatic t_fn();
    ext_en  <= 1'b1;
    ext_lvl <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, GPC_IDX_CTRL, 32'h0000_8480 | c);
      repeat (2) @(posedge pclk);
      chk("fn level", 32'(input_function_level), 32'h0000_0001 << c);
      chk("debounce", 32'(long_debounce), 32'(c inside {0, 4, 14, 15}));
    end
    apb(1'b1, GPC_IDX_CTRL, 32'h0000_8082);
    repeat (2) @(posedge pclk);
    chk("inverted", 32'(input_function_level), 32'h0000_0000);
    $display("done functions");
  endtask
  task automatic ev(input logic [15:0] ctl, input logic l0, l1, e_st, e_irq);
    apb(1'b1, GPC_IDX_CTRL, 32'(ctl));
    ext_lvl <= l0;
    repeat (3) @(posedge pclk);
    apb(1'b1, GPC_IDX_STAT, 32'h0000_0001);
    ext_lvl <= l1;
    repeat (3) @(posedge pclk);
    chk("irq", 32'(irq), 32'(e_irq));
    apb(1'b0, GPC_IDX_STAT, '0);
    chk("status", rdat, 32'(e_st));
  endtask
  task automatic t_irq();
    apb(1'b1, GPC_IDX_MASK, 32'h0000_0001);
    ev(16'h8481, 0, 1, 1, 1);
    ev(16'h8481, 1, 0, 0, 0);
    ev(16'h8081, 1, 0, 1, 1);
    ev(16'h8081, 0, 1, 0, 0);
    ev(16'h9081, 1, 0, 1, 1);
    ev(16'h9481, 0, 1, 1, 1);
    apb(1'b1, GPC_IDX_MASK, 32'h0000_0000);
    ev(16'h9481, 1, 0, 1, 0);
    $display("done interrupts");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 25);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_out();
    t_fn();
    t_irq();
    report_and_stop();
  end
endmodule // gpio6_pin_control_tb
